// [hdl/hdb_pkg.sv]
package hdb_pkg;
  // slots of the asynchronous input bundle that is synchronised
  localparam int SYNC_W = 9;
  localparam int IDX_NRZ = 0;
  localparam int IDX_ENC_CLK = 1;
  localparam int IDX_DEC_CLK = 2;
  localparam int IDX_RX_POS_N = 3;
  localparam int IDX_RX_NEG_N = 4;
  localparam int IDX_XTAL = 5;
  localparam int IDX_AIS_CLR_N = 6;
  localparam int IDX_LOOP = 7;
  localparam int IDX_REGEN_INT = 8;
  // synchroniser reset levels: the active-low receive rails idle high
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 9'h018;
  // encoder look-ahead window behind the bit being placed on the line
  localparam int ENC_WIN = 3;
  // decoder pipeline depth, symbol in to nrz out, in decode periods
  localparam int DEC_WIN = 3;
  // longest legal run of zero symbols on the line
  localparam logic [2:0] MAX_ZERO_RUN = 3'h3;
  // consecutive zero symbols that raise loss of signal
  localparam logic [3:0] LOS_ZEROS = 4'hB;
  // decoded zeros needed in one count window to clear the alarm
  localparam logic [1:0] AIS_MIN_ZEROS = 2'h3;
  // same-polarity marks in a row that count as a coding error
  localparam logic [1:0] SAME_MARK_LIMIT = 2'h3;
  // last reference phase; eight per line bit: 16.384/2.048 and 12.352/1.544 MHz
  localparam logic [2:0] XTAL_PHASE_MAX = 3'h7;
  // regenerated clock is high over these reference phases
  localparam logic [2:0] REGEN_HI_FIRST = 3'h2;
  localparam logic [2:0] REGEN_HI_LAST = 3'h5;
endpackage

// [hdl/hdb_encoder.sv]
`timescale 1ns/1ps
`default_nettype none
module hdb_encoder (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rise,
  input wire logic i_fall,
  input wire logic i_data,
  output logic o_rail_pos,
  output logic o_rail_neg
);
  logic in_bit, next_in_bit; // bit taken on the falling edge
  logic [hdb_pkg::ENC_WIN-1:0] win_b, next_win_b; // data, [0] newest
  logic [hdb_pkg::ENC_WIN-1:0] win_v, next_win_v; // violation tags
  logic last_pos, next_last_pos; // polarity of last mark, 1 = positive
  logic par, next_par; // odd marks since the last violation
  logic next_rail_pos, next_rail_neg;
  logic start; // four-zero run begins at the oldest slot
  logic mark;
  logic pol;

  ////////////////////////////////////////////////////////////////////
  // next state: substitution choice and return-to-zero rails
  always_comb begin
    next_in_bit = in_bit;
    next_win_b = win_b;
    next_win_v = win_v;
    next_last_pos = last_pos;
    next_par = par;
    next_rail_pos = o_rail_pos;
    next_rail_neg = o_rail_neg;
    mark = 1'b0;
    pol = ~last_pos;
    // the oldest slot and all newer ones are plain zeros
    start = ~|win_b & ~|win_v & ~in_bit;
    if (i_fall) begin
      next_in_bit = i_data;
      // return to zero with the encode clock low
      next_rail_pos = 1'b0;
      next_rail_neg = 1'b0;
    end
    if (i_rise) begin
      next_win_b = {win_b[hdb_pkg::ENC_WIN-2:0], in_bit};
      // tag the fourth zero of the run as the violation
      next_win_v = {win_v[hdb_pkg::ENC_WIN-2:0], start};
      if (win_v[hdb_pkg::ENC_WIN-1]) begin
        // violation repeats the last polarity
        mark = 1'b1;
        pol = last_pos;
        next_par = 1'b0;
      end else if (win_b[hdb_pkg::ENC_WIN-1] || (start && !par)) begin
        // data mark, or balancing mark on an even count
        mark = 1'b1;
        next_par = ~par;
      end
      if (mark) begin
        next_last_pos = pol;
      end
      next_rail_pos = mark & pol;
      next_rail_neg = mark & ~pol;
    end
  end

  // registers only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_bit <= 1'b0;
      win_b <= '0;
      win_v <= '0;
      last_pos <= 1'b0;
      par <= 1'b0;
      o_rail_pos <= 1'b0;
      o_rail_neg <= 1'b0;
    end else begin
      in_bit <= next_in_bit;
      win_b <= next_win_b;
      win_v <= next_win_v;
      last_pos <= next_last_pos;
      par <= next_par;
      o_rail_pos <= next_rail_pos;
      o_rail_neg <= next_rail_neg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  a_enc_viol_pol: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rise && win_v[hdb_pkg::ENC_WIN-1]
      |=> o_rail_pos == $past(last_pos) && o_rail_neg == !$past(last_pos))
    else $error("violation mark has the wrong polarity");
  a_enc_balance: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rise && start && !par
      |=> o_rail_pos == !$past(last_pos) && o_rail_neg == $past(last_pos))
    else $error("balancing mark missing on even count");
  a_enc_no_balance: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rise && start && par |=> !o_rail_pos && !o_rail_neg)
    else $error("balancing mark sent on odd count");
endmodule
`default_nettype wire

// [hdl/hdb_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module hdb_decoder (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_mark_pos,
  input wire logic i_mark_neg,
  output logic o_nrz,
  output logic o_strobe,
  output logic o_err
);
  logic [hdb_pkg::DEC_WIN-1:0] s_b, next_s_b; // data, [0] newest
  logic last_pos, next_last_pos; // polarity of last mark
  logic seen, next_seen; // any mark since reset
  logic [1:0] same_cnt, next_same_cnt; // same-polarity marks in a row
  logic next_nrz, next_err;
  logic mark, same, viol, clr_b;

  ////////////////////////////////////////////////////////////////////
  // next state: violation removal and coding-law check
  always_comb begin
    next_s_b = s_b;
    next_last_pos = last_pos;
    next_seen = seen;
    next_same_cnt = same_cnt;
    next_nrz = o_nrz;
    next_err = o_err;
    mark = i_mark_pos | i_mark_neg;
    same = mark & seen & (i_mark_pos == last_pos);
    viol = same;
    // mark three slots back with zeros between is the balancing mark
    clr_b = viol & ~s_b[1] & ~s_b[0];
    if (i_tick) begin
      next_s_b = {s_b[hdb_pkg::DEC_WIN-2:0], mark & ~viol};
      next_nrz = s_b[hdb_pkg::DEC_WIN-1] & ~clr_b;
      // both rails at once is never legal line code
      next_err = (i_mark_pos & i_mark_neg) |
        (same & (same_cnt == hdb_pkg::SAME_MARK_LIMIT - 2'h1));
      if (mark) begin
        next_last_pos = i_mark_pos;
        next_seen = 1'b1;
        if (!same) begin
          next_same_cnt = 2'h1;
        end else if (same_cnt != hdb_pkg::SAME_MARK_LIMIT) begin
          next_same_cnt = same_cnt + 2'h1;
        end
      end
    end
  end

  // registers only; strobe marks each new nrz bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_b <= '0;
      last_pos <= 1'b0;
      seen <= 1'b0;
      same_cnt <= 2'h0;
      o_nrz <= 1'b0;
      o_strobe <= 1'b0;
      o_err <= 1'b0;
    end else begin
      s_b <= next_s_b;
      last_pos <= next_last_pos;
      seen <= next_seen;
      same_cnt <= next_same_cnt;
      o_nrz <= next_nrz;
      o_strobe <= i_tick;
      o_err <= next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////
  a_dec_third_same: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_tick && same && same_cnt == 2'h2 |=> o_err)
    else $error("third same-polarity mark not flagged");
  a_dec_nrz_timing: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $changed(o_nrz) |-> $past(i_tick))
    else $error("nrz output moved off a decode edge");
  a_dec_clear_b: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_tick && clr_b |=> !o_nrz)
    else $error("balancing mark decoded as a one");
endmodule
`default_nettype wire

// [hdl/hdb_line_codec.sv]
`timescale 1ns/1ps
`default_nettype none
module hdb_line_codec (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_nrz_data,
  input wire logic i_enc_clk,
  input wire logic i_dec_clk,
  input wire logic i_rx_pos_n,
  input wire logic i_rx_neg_n,
  input wire logic i_loop_test,
  input wire logic i_regen_internal,
  input wire logic i_xtal_ref,
  input wire logic i_alarm_count_clear_n,
  output logic o_tx_positive_rail,
  output logic o_tx_negative_rail,
  output logic o_nrz_data,
  output logic o_error,
  output logic o_loss_of_signal_flag,
  output logic o_alarm_indication_out,
  output logic o_clock_recovery,
  output logic o_regen_clk
);
  ////////////////////////////////////////////////////////////////////
  // edge decoding shared by every pin clock and strobe
  function automatic logic rose(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [hdb_pkg::SYNC_W-1:0] pins; // raw pin bundle
  logic [hdb_pkg::SYNC_W-1:0] sync1; // first stage, read by sync2 only
  logic [hdb_pkg::SYNC_W-1:0] sync2; // safe to use
  logic [hdb_pkg::SYNC_W-1:0] prev; // sync2 one cycle back

  assign pins[hdb_pkg::IDX_NRZ] = i_nrz_data;
  assign pins[hdb_pkg::IDX_ENC_CLK] = i_enc_clk;
  assign pins[hdb_pkg::IDX_DEC_CLK] = i_dec_clk;
  assign pins[hdb_pkg::IDX_RX_POS_N] = i_rx_pos_n;
  assign pins[hdb_pkg::IDX_RX_NEG_N] = i_rx_neg_n;
  assign pins[hdb_pkg::IDX_XTAL] = i_xtal_ref;
  assign pins[hdb_pkg::IDX_AIS_CLR_N] = i_alarm_count_clear_n;
  assign pins[hdb_pkg::IDX_LOOP] = i_loop_test;
  assign pins[hdb_pkg::IDX_REGEN_INT] = i_regen_internal;

  // every pin takes the same two stages, so relative timing between
  // the data pin and its clock pin is kept
  genvar g;
  generate
    for (g = 0; g < hdb_pkg::SYNC_W; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          // idle levels, so no false mark or edge follows reset
          sync1[g] <= hdb_pkg::SYNC_IDLE[g];
          sync2[g] <= hdb_pkg::SYNC_IDLE[g];
          prev[g] <= hdb_pkg::SYNC_IDLE[g];
        end else begin
          sync1[g] <= pins[g];
          sync2[g] <= sync1[g];
          prev[g] <= sync2[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // one-cycle enables from the pin clocks, and levels from the two mode pins
  logic enc_rise; // encode clock rising: rails launched
  logic enc_fall; // encode clock falling: nrz bit taken
  logic dec_pin_rise; // external decode clock rising
  logic xtal_rise; // crystal reference rising
  logic loop_on; // loop-back selected
  logic regen_int; // decode timed by internal regenerator
  logic dec_tick; // decoder sampling point

  // encode and decode enables come from unrelated pins
  assign enc_rise = rose(prev[hdb_pkg::IDX_ENC_CLK],
    sync2[hdb_pkg::IDX_ENC_CLK]);
  assign enc_fall = fell(prev[hdb_pkg::IDX_ENC_CLK],
    sync2[hdb_pkg::IDX_ENC_CLK]);
  assign dec_pin_rise = rose(prev[hdb_pkg::IDX_DEC_CLK],
    sync2[hdb_pkg::IDX_DEC_CLK]);
  assign xtal_rise = rose(prev[hdb_pkg::IDX_XTAL],
    sync2[hdb_pkg::IDX_XTAL]);
  assign loop_on = sync2[hdb_pkg::IDX_LOOP];
  assign regen_int = sync2[hdb_pkg::IDX_REGEN_INT];

  ////////////////////////////////////////////////////////////////////
  // encoder: nrz in, return-to-zero rails out
  hdb_encoder u_enc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_rise(enc_rise),
    .i_fall(enc_fall),
    .i_data(sync2[hdb_pkg::IDX_NRZ]),
    .o_rail_pos(o_tx_positive_rail),
    .o_rail_neg(o_tx_negative_rail)
  );

  ////////////////////////////////////////////////////////////////////
  // receive marks; loop-back takes the transmit rails straight across
  logic mark_pos; // positive mark at decoder input
  logic mark_neg; // negative mark at decoder input
  logic mark_any;

  always_comb begin
    if (loop_on) begin
      mark_pos = o_tx_positive_rail;
      mark_neg = o_tx_negative_rail;
    end else begin
      // receive rails are active low
      mark_pos = ~sync2[hdb_pkg::IDX_RX_POS_N];
      mark_neg = ~sync2[hdb_pkg::IDX_RX_NEG_N];
    end
    mark_any = mark_pos | mark_neg;
  end

  ////////////////////////////////////////////////////////////////////
  // recovery signal and digital clock regenerator
  logic [2:0] phase, next_phase; // reference phase within a bit
  logic next_regen;
  logic regen_rise; // internal decode edge

  // the line bit is eight reference cycles; a mark edge realigns
  // phase, so the regenerated edge lands mid pulse. a long zero run
  // leaves it free-running on the reference, which may be shared.
  always_comb begin
    next_phase = phase;
    if (mark_any && !o_clock_recovery) begin
      next_phase = 3'h0;
    end else if (xtal_rise) begin
      next_phase = (phase == hdb_pkg::XTAL_PHASE_MAX) ? 3'h0 :
        phase + 3'h1;
    end
    next_regen = (next_phase >= hdb_pkg::REGEN_HI_FIRST) &&
      (next_phase <= hdb_pkg::REGEN_HI_LAST);
    regen_rise = next_regen & ~o_regen_clk;
    dec_tick = regen_int ? regen_rise : dec_pin_rise;
  end

  // registers only; recovery output is the or of both rails
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= 3'h0;
      o_regen_clk <= 1'b0;
      o_clock_recovery <= 1'b0;
    end else begin
      phase <= next_phase;
      o_regen_clk <= next_regen;
      o_clock_recovery <= mark_any;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decoder: marks in, nrz out with coding error
  logic dec_strobe; // high with each new decoded bit, one cycle after the tick

  hdb_decoder u_dec (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(dec_tick),
    .i_mark_pos(mark_pos),
    .i_mark_neg(mark_neg),
    .o_nrz(o_nrz_data),
    .o_strobe(dec_strobe),
    .o_err(o_error)
  );

  ////////////////////////////////////////////////////////////////////
  // loss of input: zero symbols in a row at the decoder input
  logic [3:0] los_cnt, next_los_cnt;
  logic next_los;

  always_comb begin
    next_los_cnt = los_cnt;
    next_los = o_loss_of_signal_flag;
    if (dec_tick) begin
      if (mark_any) begin
        next_los_cnt = 4'h0;
      end else if (los_cnt != hdb_pkg::LOS_ZEROS) begin
        next_los_cnt = los_cnt + 4'h1;
      end
      next_los = (next_los_cnt == hdb_pkg::LOS_ZEROS);
    end
  end

  // registers only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      los_cnt <= 4'h0;
      o_loss_of_signal_flag <= 1'b0;
    end else begin
      los_cnt <= next_los_cnt;
      o_loss_of_signal_flag <= next_los;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // all-ones alarm: decoded zeros counted while count-clear is high
  logic [1:0] zero_cnt, next_zero_cnt;
  logic next_ais;
  logic clr_fall; // count-clear falling: alarm decided
  logic clr_high;

  // the count is taken in the system clock domain after the decoder,
  // so the alarm moves a couple of cycles after the pin edge
  always_comb begin
    clr_fall = fell(prev[hdb_pkg::IDX_AIS_CLR_N],
      sync2[hdb_pkg::IDX_AIS_CLR_N]);
    clr_high = sync2[hdb_pkg::IDX_AIS_CLR_N];
    next_zero_cnt = zero_cnt;
    next_ais = o_alarm_indication_out;
    if (clr_fall) begin
      // too few zeros means an all-ones stream
      next_ais = (zero_cnt < hdb_pkg::AIS_MIN_ZEROS);
      next_zero_cnt = 2'h0;
    end else if (!clr_high) begin
      next_zero_cnt = 2'h0; // held clear while low
    end else if (dec_strobe && !o_nrz_data &&
        zero_cnt != hdb_pkg::AIS_MIN_ZEROS) begin
      next_zero_cnt = zero_cnt + 2'h1;
    end
  end

  // registers only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zero_cnt <= 2'h0;
      o_alarm_indication_out <= 1'b0;
    end else begin
      zero_cnt <= next_zero_cnt;
      o_alarm_indication_out <= next_ais;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checking helpers: zero symbols in a row on the transmit rails
  logic enc_rise_d;
  logic [2:0] tx_zero_run;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enc_rise_d <= 1'b0;
      tx_zero_run <= 3'h0;
    end else begin
      enc_rise_d <= enc_rise;
      if (enc_rise_d) begin
        if (o_tx_positive_rail || o_tx_negative_rail) begin
          tx_zero_run <= 3'h0;
        end else if (tx_zero_run != 3'h7) begin
          tx_zero_run <= tx_zero_run + 3'h1;
        end
      end
    end
  end

  a_tx_zero_run: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    tx_zero_run <= hdb_pkg::MAX_ZERO_RUN)
    else $error("more than three zero symbols on the line");
  a_tx_rail_timing: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_tx_positive_rail) || $rose(o_tx_negative_rail)
      |-> $past(enc_rise))
    else $error("rail mark launched off an encode rising edge");
  a_tx_rail_rz: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    enc_fall |=> !o_tx_positive_rail && !o_tx_negative_rail)
    else $error("rail not returned to zero");
  a_los_set: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    dec_tick && !mark_any && los_cnt == 4'hA |=> o_loss_of_signal_flag)
    else $error("loss flag late after eleven zeros");
  a_los_clear: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    dec_tick && mark_any |=> !o_loss_of_signal_flag && los_cnt == 4'h0)
    else $error("mark did not clear loss of signal");
  a_ais_decide: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    clr_fall |=> o_alarm_indication_out == ($past(zero_cnt) < 2'h3)
      && zero_cnt == 2'h0)
    else $error("alarm decided wrongly at count clear");
  a_loop_recovery: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    loop_on |=> o_clock_recovery ==
      ($past(o_tx_positive_rail) || $past(o_tx_negative_rail)))
    else $error("recovery does not follow rails in loop-back");
  a_regen_align: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    mark_any && !o_clock_recovery |=> phase == 3'h0 && !o_regen_clk)
    else $error("regenerator not realigned on mark");
endmodule
`default_nettype wire

// [bench/hdb_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hdb_line_model (
  input wire logic i_clk,
  input wire logic i_sym_pos,
  input wire logic i_sym_neg,
  output var logic o_dec_clk,
  output var logic o_rx_pos_n,
  output var logic o_rx_neg_n
);
  // half period of the decode clock, in system cycles
  localparam int HALF = 7;
  // position inside the current half period
  int cnt;
  ////////////////////////////////////////////////////////////////////////
  // receiver idles with no mark on either rail
  initial begin
    cnt = 0;
    o_dec_clk = 1'b0;
    o_rx_pos_n = 1'b1;
    o_rx_neg_n = 1'b1;
  end
  // free decode clock; symbols move on its falling edge so the
  // decoder's rising-edge sample always lands mid-symbol
  always @(posedge i_clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      o_dec_clk <= #1 ~o_dec_clk;
      if (o_dec_clk) begin
        // active-low outputs: a mark pulls its rail low
        o_rx_pos_n <= #1 ~i_sym_pos;
        o_rx_neg_n <= #1 ~i_sym_neg;
      end
    end
  end
endmodule
`default_nettype wire

// [bench/hdb_line_codec_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module hdb_line_codec_bench;
  localparam int NB = 26;
  // zero runs with odd and even mark counts ahead, two runs back to back
  localparam logic [25:0] PAT = 26'h0218047;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic nrz_in = 1'b0;
  logic enc_clk = 1'b0;
  logic xtal = 1'b0;
  logic loop_test = 1'b0;
  logic clr_n = 1'b0;
  logic regen_sel = 1'b0;
  logic sym_pos = 1'b0;
  logic sym_neg = 1'b0;
  wire logic dec_clk, rx_pos_n, rx_neg_n;
  wire logic tx_pos, tx_neg, nrz_out, err, los, alarm_indication_out, rec, regen;
  int enc_cnt = 0;
  int xtal_cnt = 0;
  int comparisons = 0;
  int miscompares = 0;
  int last_pol = -1;
  logic bits [NB];
  int syms [NB];
  ////////////////////////////////////////////////////////////////////////
  // 100 MHz system clock; encode 120 ns and reference 80 ns after edges
  always #5 clk = ~clk;
  always @(posedge clk) begin
    enc_cnt <= (enc_cnt == 5) ? 0 : enc_cnt + 1;
    xtal_cnt <= (xtal_cnt == 3) ? 0 : xtal_cnt + 1;
    if (enc_cnt == 5) begin
      enc_clk <= #1 ~enc_clk;
    end
    if (xtal_cnt == 3) begin
      xtal <= #1 ~xtal;
    end
  end
  hdb_line_model line (
    .i_clk(clk), .i_sym_pos(sym_pos), .i_sym_neg(sym_neg),
    .o_dec_clk(dec_clk), .o_rx_pos_n(rx_pos_n), .o_rx_neg_n(rx_neg_n)
  );
  hdb_line_codec dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_nrz_data(nrz_in),
    .i_enc_clk(enc_clk), .i_dec_clk(dec_clk), .i_rx_pos_n(rx_pos_n),
    .i_rx_neg_n(rx_neg_n), .i_loop_test(loop_test),
    .i_regen_internal(regen_sel), .i_xtal_ref(xtal),
    .i_alarm_count_clear_n(clr_n),
    .o_tx_positive_rail(tx_pos), .o_tx_negative_rail(tx_neg),
    .o_nrz_data(nrz_out), .o_error(err), .o_loss_of_signal_flag(los),
    .o_alarm_indication_out(alarm_indication_out), .o_clock_recovery(rec), .o_regen_clk(regen)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic check_bit(input string name, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", name, e, g);
    end
  endtask
  task automatic check_int(input string name, input int e, input int g);
    comparisons++;
    if (g != e) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", name, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // the four zeros held at reset leave a positive B00V on the line, so
  // data starts with the last mark positive and an even count
  function automatic void ref_encode();
    int last;
    int par;
    int i;
    last = 1;
    par = 0;
    i = 0;
    while (i < NB) begin
      if (i + 3 < NB && !(bits[i] | bits[i+1] | bits[i+2] | bits[i+3])) begin
        syms[i] = 0;
        if (par % 2 == 0) begin
          last = -last;
          syms[i] = last;
        end
        syms[i+1] = 0;
        syms[i+2] = 0;
        syms[i+3] = last;
        par = 0;
        i += 4;
      end else begin
        if (bits[i]) begin
          last = -last;
          par++;
        end
        syms[i] = bits[i] ? last : 0;
        i++;
      end
    end
  endfunction
  // one received slot: 1 positive, -1 negative, 2 both rails, 0 none
  task automatic put_sym(input int s);
    sym_pos = (s == 1 || s == 2);
    sym_neg = (s == -1 || s == 2);
    if (s == 1 || s == -1) begin
      last_pol = s;
    end
    @(negedge dec_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // bit set mid-period, sampled on the fall, seen four falls later
  task automatic test_encoder();
    for (int i = 0; i < NB + 4; i++) begin
      @(posedge enc_clk);
      nrz_in = (i < NB) ? bits[i] : 1'b1;
      @(negedge enc_clk);
      if (i >= 4) begin
        check_bit("tx_pos", syms[i-4] == 1, tx_pos);
        check_bit("tx_neg", syms[i-4] == -1, tx_neg);
      end
    end
  endtask
  // no decoded zeros while counting, so the alarm must be set; ends on a
  // positive mark so the negative first mark of the data alternates
  task automatic test_all_ones();
    for (int k = 0; k < 12; k++) begin
      put_sym(k % 2 == 0 ? -1 : 1);
      if (k == 5) begin
        clr_n = 1'b1;
      end
    end
    clr_n = 1'b0;
    repeat (6) @(posedge clk);
    check_bit("alarm", 1'b1, alarm_indication_out);
  endtask
  task automatic test_decoder();
    clr_n = 1'b1;
    for (int j = 0; j < NB + 4; j++) begin
      put_sym(j < NB ? syms[j] : 0);
      if (j >= 4) begin
        check_bit("nrz_out", bits[j-4], nrz_out);
      end
      if (j >= 1 && j <= NB) begin
        check_bit("recovery", syms[j-1] != 0, rec);
      end
      check_bit("error", 1'b0, err);
    end
    clr_n = 1'b0;
    repeat (6) @(posedge clk);
    check_bit("alarm", 1'b0, alarm_indication_out);
  endtask
  // third same-polarity mark, then both rails at once
  task automatic test_errors();
    logic seen;
    for (int t = 0; t < 2; t++) begin
      seen = 1'b0;
      if (t == 0) begin
        put_sym(last_pol);
        put_sym(0);
        put_sym(last_pol);
      end else begin
        put_sym(2);
      end
      repeat (6) begin
        put_sym(0);
        seen = seen | (err === 1'b1);
      end
      check_bit("error", 1'b1, seen);
      check_bit("error_drop", 1'b0, err);
    end
  endtask
  task automatic test_loss();
    put_sym(-last_pol);
    repeat (11) put_sym(0);
    check_bit("loss", 1'b0, los);
    put_sym(-last_pol);
    check_bit("loss", 1'b1, los);
    put_sym(0);
    check_bit("loss", 1'b0, los);
  endtask
  // receive rail held marked; recovery must follow transmit pulses only
  task automatic test_loop();
    loop_test = 1'b1;
    put_sym(1);
    repeat (4) begin
      @(posedge enc_clk);
      check_bit("loop_rec_low", 1'b0, rec);
      @(negedge enc_clk);
      check_bit("loop_rec_high", 1'b1, rec);
    end
    loop_test = 1'b0;
    put_sym(0);
  endtask
  // one sample per reference phase: half of eight phases are high
  task automatic test_regen();
    int highs;
    highs = 0;
    repeat (16) @(posedge clk);
    repeat (8) begin
      @(negedge xtal);
      highs += (regen === 1'b1) ? 1 : 0;
    end
    check_int("regen_high", 4, highs);
  endtask
  // decode timed by the regenerator: one tick per eight reference cycles,
  // so zeros count far slower than on the external decode clock
  task automatic test_regen_tick();
    regen_sel = 1'b1;
    put_sym(1);
    put_sym(1);
    put_sym(0);
    repeat (30) @(negedge dec_clk);
    check_bit("loss_regen", 1'b0, los);
    repeat (40) @(negedge dec_clk);
    check_bit("loss_regen", 1'b1, los);
    regen_sel = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < NB; i++) begin
      bits[i] = PAT[NB-1-i];
    end
    ref_encode();
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    test_encoder();
    test_all_ones();
    test_decoder();
    test_errors();
    test_loss();
    test_loop();
    test_regen();
    test_regen_tick();
    report_and_stop();
  end
  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
